// ### isc_pkg.sv
// Package for the interrupt status capture block: offsets, flag
// layout, source kinds, control fields and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus and one clock.
package isc_pkg;

  // Register map, byte addresses
  localparam int         AXI_AW    = 5;
  localparam logic [4:0] OFS_STAT0 = 5'h00;
  localparam logic [4:0] OFS_STAT1 = 5'h04;
  localparam logic [4:0] OFS_MASK0 = 5'h08;
  localparam logic [4:0] OFS_MASK1 = 5'h0c;
  localparam logic [4:0] OFS_CTRL  = 5'h10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Flag vector: bits 31..0 in word 0, bits 38..32 in word 1
  localparam int NFLAG = 39;
  localparam int W0    = 32;
  localparam int W1    = NFLAG - W0;

  // Source kinds per flag bit; a bit in no mask is event based
  localparam logic [38:0] KIND_COND   = 39'h07_ff00_0000;
  localparam logic [38:0] KIND_FOLLOW = 39'h78_0000_0000;
  localparam logic [38:0] ONESHOT     = 39'h00_0300_3000;
  localparam logic [38:0] RX_ONESHOT  = 39'h00_0100_1000;
  localparam logic [38:0] TX_ONESHOT  = 39'h00_0200_2000;

  // Reset values
  localparam logic [38:0] MASK_RST  = 39'h7f_ffff_ffff;
  localparam logic [38:0] ARMED_RST = 39'h7f_ffff_ffff;
  localparam int          CTRL_W    = 5;
  localparam logic [4:0]  CTRL_RST  = 5'h00;
  localparam logic [1:0]  ALERT_OFF = 2'h0;

  // Control word, bit 0 upward from the last field
  typedef struct packed {
    logic [1:0] alert_mode;
    logic       headset_bias_sense_enable;
    logic       mic_level_sense_powerdown;
    logic       global_power_down;
  } isc_ctrl_s;

  // Source inputs; first field is bit 38
  typedef struct packed {
    logic ring_plug_state, ring_unplug_state;
    logic tip_plug_state, tip_unplug_state;
    logic pll_locked, supply_monitor_trip;
    logic capture_path_locked, playback_path_locked;
    logic power_down_complete;
    logic rate_conv_in_locked, rate_conv_out_locked;
    logic rate_conv_in_unlocked, rate_conv_out_unlocked;
    logic port_tx_no_frame_clock, port_rx_no_frame_clock;
    logic short_detected, short_release;
    logic detect_rise, detect_fall;
    logic tip_sense_unplug, tip_sense_plug;
    logic headset_bias_sensed, headset_autodetect_complete;
    logic port_tx_early, port_tx_late, port_tx_state_fault;
    logic port_rx_early, port_rx_late, port_rx_fault;
    logic port_rx_overload;
    logic mixer_b_overflow, mixer_a_overflow;
    logic equalizer_overflow, equalizer_biquad_overflow;
    logic capture_overflow;
    logic ring_plug_debounced, ring_unplug_debounced;
    logic tip_plug_debounced, tip_unplug_debounced;
  } isc_src_s;

endpackage

// ### isc_irq_capture.sv
// Interrupt status capture: sticky status flags, masks and one
// interrupt line, reached over AXI4-Lite.
// Assumes sources are synchronous to aclk; event inputs are one-cycle
// pulses, condition and plug-state inputs are levels.
//
// Summary of operation
// - A condition flag sets while its condition is present and clears only on a read or a write of one made once the condition is gone.
// - An event flag clears when read and reads 0 again until a new event arrives.
// - Raising global power-down clears all flags but the plug-state bits unless detection is live, alert mode is nonzero and an interrupt was seen.
// - The four debounced tip and ring plug and unplug flags are events.
// - Capture overflow and the two mixer and two equalizer overflow flags are events.
// - Serial-port error and timing flags are events; missing frame clock and rate converter lock flags are conditions.
// - Headset autodetect completion is an event and power-down completion is a condition.
// - Every headset flag is an event.
// - Playback lock, capture lock, supply monitor trip and PLL lock are conditions.
// - The tip and ring plug-state bits follow their plug-state inputs instead of clearing on read.
// - After a receive early frame clock, transmit state fault or missing frame clock the first read gives 1 and later reads 0.
// - Those one-shot detections rearm only on a valid frame clock edge or on leaving transmit overflow.
// - The interrupt stays high until every set and unmasked flag has been read or cleared by writing a one to it.
// - A masked event still sets its flag but leaves the interrupt alone.
//
// Chosen here: the address map and register access over AXI4-Lite.

`timescale 1ns/1ps

module isc_irq_capture
  import isc_pkg::*;
#(
  parameter int ADDR_W = AXI_AW
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Interrupt sources
  input  wire isc_src_s          src,
  // One-shot rearm strobes
  input  wire logic              rx_frame_clock_valid,
  input  wire logic              tx_frame_clock_valid,
  input  wire logic              tx_overflow_exit,
  // Interrupt, active high level
  output logic                   irq
);

  // Refuse an address bus too narrow for the map
  if (ADDR_W < AXI_AW) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  // Bus state
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // Block state
  logic [NFLAG-1:0]  flag_reg;
  logic [NFLAG-1:0]  mask_reg;
  logic [NFLAG-1:0]  armed_reg;
  isc_ctrl_s         ctrl_reg;
  logic              pd_q_reg;
  logic              retained_reg;
  logic              irq_reg;

  // Handshakes and decode
  logic              aw_hs;
  logic              w_hs;
  logic              b_hs;
  logic              r_hs;
  logic              rd_take;
  logic              wr_exec;
  logic              wr_stat0;
  logic              wr_stat1;
  logic              wr_mask0;
  logic              wr_mask1;
  logic              wr_ctrl;
  logic              wr_hit;
  logic [31:0]       wmask;
  isc_ctrl_s         wctrl;

  // Read mux
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic [NFLAG-1:0]  rd_sel;

  // Flag control
  logic [NFLAG-1:0]  srcv;
  logic [NFLAG-1:0]  eff;
  logic [NFLAG-1:0]  rearm;
  logic [NFLAG-1:0]  wclr;
  logic [NFLAG-1:0]  clr_req;
  logic              pd_rise;
  logic              retain;
  logic              mode_clr;
  logic              pd_clear;

  // Outputs come straight from their flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;

  // Channel handshakes
  assign aw_hs   = s_axi_awvalid & awready_reg;
  assign w_hs    = s_axi_wvalid & wready_reg;
  assign b_hs    = bvalid_reg & s_axi_bready;
  assign r_hs    = rvalid_reg & s_axi_rready;
  assign rd_take = s_axi_arvalid & arready_reg;
  assign wr_exec = aw_got_reg & w_got_reg & ~bvalid_reg;

  // Write address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end else begin
      if (aw_hs) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_got_reg  <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_got_reg  <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_exec) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end
      // Ready again only after the response, one write at a time
      if (b_hs) begin
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_exec) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Write decode against the full address, so no aliases
  assign wr_stat0 = wr_exec & (awaddr_reg == ADDR_W'(OFS_STAT0));
  assign wr_stat1 = wr_exec & (awaddr_reg == ADDR_W'(OFS_STAT1));
  assign wr_mask0 = wr_exec & (awaddr_reg == ADDR_W'(OFS_MASK0));
  assign wr_mask1 = wr_exec & (awaddr_reg == ADDR_W'(OFS_MASK1));
  assign wr_ctrl  = wr_exec & (awaddr_reg == ADDR_W'(OFS_CTRL));
  assign wr_hit   = wr_stat0 | wr_stat1 | wr_mask0 | wr_mask1 | wr_ctrl;

  // Byte lanes
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wctrl = isc_ctrl_s'(wdata_reg[CTRL_W-1:0]);

  // Writing ones to a status word clears like a read
  assign wclr = {wr_stat1 ? wdata_reg[W1-1:0] & wmask[W1-1:0] : W1'(0),
                 wr_stat0 ? wdata_reg & wmask : W0'(0)};

  // Mask registers, set bit means masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= MASK_RST;
    end else begin
      if (wr_mask0) begin
        mask_reg[W0-1:0] <= (mask_reg[W0-1:0] & ~wmask) |
                            (wdata_reg & wmask);
      end
      if (wr_mask1) begin
        mask_reg[NFLAG-1:W0] <= (mask_reg[NFLAG-1:W0] & ~wmask[W1-1:0])
                              | (wdata_reg[W1-1:0] & wmask[W1-1:0]);
      end
    end
  end

  // Control register lives in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= isc_ctrl_s'(CTRL_RST);
    end else if (wr_ctrl && wstrb_reg[0]) begin
      ctrl_reg <= wctrl;
    end
  end

  // Read mux; status reads also select the flags to clear
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    rd_sel  = '0;
    case (s_axi_araddr)
      ADDR_W'(OFS_STAT0): begin
        rd_data        = flag_reg[W0-1:0];
        rd_sel[W0-1:0] = '1;
      end
      ADDR_W'(OFS_STAT1): begin
        rd_data[W1-1:0]    = flag_reg[NFLAG-1:W0];
        rd_sel[NFLAG-1:W0] = '1;
      end
      ADDR_W'(OFS_MASK0): rd_data = mask_reg[W0-1:0];
      ADDR_W'(OFS_MASK1): rd_data[W1-1:0] = mask_reg[NFLAG-1:W0];
      ADDR_W'(OFS_CTRL):  rd_data[CTRL_W-1:0] = ctrl_reg;
      default:            rd_ok = 1'b0;
    endcase
  end

  // Read channel; data is sampled in the cycle the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (rd_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_data;
      rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // Clear requests from reads and from write-one-to-clear
  assign clr_req = (rd_sel & {NFLAG{rd_take}}) | wclr;
  assign srcv    = src;

  // Rearm strobes, split per direction
  assign rearm = (RX_ONESHOT & {NFLAG{rx_frame_clock_valid}}) |
                 (TX_ONESHOT &
                  {NFLAG{tx_frame_clock_valid | tx_overflow_exit}});

  // Power-down edge and the retention exception
  assign pd_rise  = ctrl_reg.global_power_down & ~pd_q_reg;
  assign retain   = (~ctrl_reg.mic_level_sense_powerdown |
                     ctrl_reg.headset_bias_sense_enable) &
                    (ctrl_reg.alert_mode != ALERT_OFF) &
                    irq_reg;
  assign mode_clr = wr_ctrl & wstrb_reg[0] & retained_reg &
                    (wctrl.alert_mode == ALERT_OFF);
  assign pd_clear = (pd_rise & ~retain) | mode_clr;

  // Power-down edge detect and retention tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_q_reg     <= 1'b0;
      retained_reg <= 1'b0;
    end else begin
      pd_q_reg <= ctrl_reg.global_power_down;
      if (pd_rise && retain) begin
        retained_reg <= 1'b1;
      end else if (mode_clr || !ctrl_reg.global_power_down) begin
        retained_reg <= 1'b0;
      end
    end
  end

  // One flag per source; the kind masks pick the behaviour.
  // Condition sources set every cycle they are present, so a clear
  // only lands once the condition has gone away.
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag

    // A disarmed one-shot source is seen as absent
    assign eff[i] = srcv[i] & (armed_reg[i] | ~ONESHOT[i]);

    // Status bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_reg[i] <= 1'b0;
      end else if (KIND_FOLLOW[i]) begin
        flag_reg[i] <= srcv[i];
      end else if (eff[i]) begin
        // Set beats any clear in the same cycle
        flag_reg[i] <= 1'b1;
      end else if (pd_clear) begin
        flag_reg[i] <= 1'b0;
      end else if (clr_req[i]) begin
        flag_reg[i] <= 1'b0;
      end
    end

    // Arming for the one-shot serial-port sources
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        armed_reg[i] <= ARMED_RST[i];
      end else if (rearm[i]) begin
        armed_reg[i] <= 1'b1;
      end else if (eff[i] && ONESHOT[i]) begin
        armed_reg[i] <= 1'b0;
      end
    end

  end

  // Interrupt: any set and unmasked flag; masked flags never count.
  // One cycle behind the flags to keep the pin glitch free.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_reg & ~mask_reg);
    end
  end

endmodule

// ### isc_host.sv
// Host model: AXI4-Lite master that reaches the capture block's
// registers. Assumes one clock; tb_top supplies hang() for a stall.
`timescale 1ns/1ps
module isc_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [4:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [4:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end

  // One write; each channel drops valid only at its own take
  task automatic wr(input logic [4:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    // Sometimes late with bready, so a held response gets exercised
    s_axi_bready  <= 1'($urandom_range(1));
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    if (!(s_axi_bvalid && s_axi_bready)) begin
      tb_top.hang();
    end else begin
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
    end
  endtask

  // One read; data is taken at the edge that sees rvalid and rready
  task automatic rd(input logic [4:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    // Sometimes late with rready, so held read data gets exercised
    s_axi_rready  <= 1'($urandom_range(1));
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    if (!(s_axi_rvalid && s_axi_rready)) begin
      tb_top.hang();
    end else begin
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
endmodule

// ### isc_irq_capture_assertions.sv
// Checker for the capture block, bound to its top ports.
// Assumes the single aclk domain and synchronous aresetn.
`timescale 1ns/1ps
module isc_irq_capture_assertions
  import isc_pkg::*;
#(
  parameter int ADDR_W = AXI_AW
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Sources and interrupt
  input wire isc_src_s          src,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read take, and a take of the upper status word
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence stat1_take;
    ar_take ##0 s_axi_araddr == OFS_STAT1;
  endsequence

  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_bad_addr: assert property (ar_take ##0 s_axi_araddr > OFS_CTRL |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_follow_state: assert property (stat1_take |=>
    s_axi_rdata[6:3] == $past(src[38:35], 2))
    else $error("plug state bits not following input");
  a_cond_sticky: assert property (stat1_take ##0
    $past(src.pll_locked) |=> s_axi_rdata[2])
    else $error("present condition read as clear");
  a_irq_fall: assert property ($fell(irq) |->
    $past(s_axi_arvalid && s_axi_arready, 2) || $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2) || $past(src[38:35], 2) != $past(src[38:35], 3))
    else $error("irq dropped without a read or write");
  a_irq_cause: assert property ($rose(irq) |->
    $past(|src, 2) || $past(s_axi_bvalid))
    else $error("irq raised without a cause");
endmodule

bind isc_irq_capture isc_irq_capture_assertions #(.ADDR_W(ADDR_W))
  i_chk (.*);

// ### tb_top.sv
// Testbench for the capture block: host model on the bus, sources
// and rearm strobes driven here. Assumes 200 MHz aclk.
`timescale 1ns/1ps
module tb_top;
  import isc_pkg::*;
  logic        aclk, aresetn, irq;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  rearm;
  isc_src_s    src;
  int          error_cnt, checked, b, k;
  int          osb[4] = '{12, 13, 24, 25};
  logic [2:0]  osr[4] = '{3'h1, 3'h4, 3'h1, 3'h2};

  isc_irq_capture i_dut (.*, .rx_frame_clock_valid(rearm[0]),
    .tx_frame_clock_valid(rearm[1]), .tx_overflow_exit(rearm[2]));
  isc_host i_host (.*);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("BAD %0t bus handshake stalled", $time);
    tally_and_finish();
  endtask

  // Sources change at an edge; plug-state bits get random noise
  task automatic setsrc(input logic [38:0] v);
    @(posedge aclk);
    src <= isc_src_s'(v | {4'($urandom_range(15)), 35'h0});
  endtask

  task automatic pulse(input logic [38:0] v);
    setsrc(v);
    setsrc(39'h0);
  endtask

  task automatic strobe(input logic [2:0] v);
    @(posedge aclk);
    rearm <= v;
    @(posedge aclk);
    rearm <= 3'h0;
  endtask

  // Read the word that holds flag n and compare that bit
  task automatic rbit(input int n, input logic e);
    i_host.rd(n > 31 ? OFS_STAT1 : OFS_STAT0, d, r);
    cmp({31'h0, d[n % 32]}, {31'h0, e});
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge aclk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask

  initial begin
    aresetn = 1'b0;
    src = '0;
    rearm = 3'h0;
    void'($urandom(32'hba2e));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    i_host.rd(OFS_MASK1, d, r);
    cmp(d, 32'h7f);
    // Every plain event flag: one read shows it, the next is clear
    for (b = 0; b < 24; b++) begin
      if (b == 12 || b == 13) continue;
      repeat ($urandom_range(3)) @(posedge aclk);
      pulse(39'h1 << b);
      rbit(b, 1'b1);
      rbit(b, 1'b0);
    end
    // Event in the very cycle its flag is cleared must survive
    fork
      i_host.rd(OFS_STAT0, d, r);
      pulse(39'h10);
    join
    rbit(4, 1'b1);
    // Condition flags stick while present and one read beyond
    for (b = 26; b < 35; b++) begin
      setsrc(39'h1 << b);
      rbit(b, 1'b1);
      rbit(b, 1'b1);
      setsrc(39'h0);
      rbit(b, 1'b1);
      rbit(b, 1'b0);
    end
    // One-shot flags stay quiet until their own rearm strobe
    for (k = 0; k < 4; k++) begin
      pulse(39'h1 << osb[k]);
      rbit(osb[k], 1'b1);
      pulse(39'h1 << osb[k]);
      rbit(osb[k], 1'b0);
      strobe(osr[k]);
      pulse(39'h1 << osb[k]);
      rbit(osb[k], 1'b1);
    end
    // Masked flag is silent; unmasked ones hold irq until all read
    pulse(39'h10);
    irq_is(1'b0);
    i_host.wr(OFS_MASK0, 32'hffffffef, r);
    i_host.wr(OFS_MASK1, 32'h7b, r);
    setsrc(39'h1 << 34);
    irq_is(1'b1);
    rbit(4, 1'b1);
    irq_is(1'b1);
    setsrc(39'h0);
    rbit(34, 1'b1);
    irq_is(1'b0);
    // Power-down with alerting on keeps the raised interrupt
    pulse(39'h10);
    i_host.wr(OFS_CTRL, 32'h19, r);
    irq_is(1'b1);
    i_host.wr(OFS_CTRL, 32'h1, r);
    irq_is(1'b0);
    i_host.wr(OFS_CTRL, 32'h0, r);
    pulse(39'h10);
    i_host.wr(OFS_CTRL, 32'h1, r);
    rbit(4, 1'b0);
    // Bias sensing alone keeps the interrupt; with both off it clears
    i_host.wr(OFS_CTRL, 32'h0, r);
    pulse(39'h10);
    i_host.wr(OFS_CTRL, 32'hf, r);
    irq_is(1'b1);
    i_host.wr(OFS_CTRL, 32'h7, r);
    irq_is(1'b0);
    i_host.wr(OFS_CTRL, 32'h0, r);
    pulse(39'h10);
    i_host.wr(OFS_CTRL, 32'hb, r);
    irq_is(1'b0);
    // Writing ones to a status word clears those flags too
    pulse(39'h20);
    i_host.wr(OFS_STAT0, 32'h20, r);
    cmp({30'h0, r}, {30'h0, RESP_OKAY});
    rbit(5, 1'b0);
    // Unmapped places answer with an error
    i_host.rd(5'h14, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    i_host.wr(5'h18, 32'hffffffff, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    tally_and_finish();
  end
endmodule
